// ### logic/cma_consts.svh
// Purpose: Offsets, field codes, reset values and sizes for the core
//          memory addressing block.
// Assumes: Included by its bare name from every file that needs it.
// Notes:   Definitions only.
`ifndef CMA_CONSTS_SVH
`define CMA_CONSTS_SVH

// Program memory.
`define CMA_PC_W 21
`define CMA_PC_RESET 21'h000000
`define CMA_PC_STEP 21'h000002

// Data memory.
`define CMA_DADDR_W 12
`define CMA_RAM_DEPTH 3904
`define CMA_RAM_TOP 12'hF3F
`define CMA_BANK_IMPL 16'hFFFF
`define CMA_ACCESS_SPLIT 8'h60
`define CMA_ACCESS_LO_BANK 4'h0
`define CMA_ACCESS_HI_BANK 4'hF
`define CMA_BANKPTR_ADDR 12'hFE0
`define CMA_BANKPTR_RESET 4'h0
`define CMA_USB_BANK_LO 4'h4
`define CMA_USB_BANK_HI 4'h7

// Opcode fields.
`define CMA_SECOND_PREFIX 4'hF
`define CMA_OP_FMOVE 4'hC
`define CMA_OP_GOTO 8'hEF
`define CMA_OP_CALL 7'h76
`define CMA_OP_LFSR 10'h3B8
`define CMA_OP_LDBANK 12'h010
`define CMA_OP_BRA 5'h1A
`define CMA_OP_RCALL 5'h1B
`define CMA_OP_BCOND 5'h1C
`define CMA_FILE_TOP_LO 4'h2
`define CMA_FILE_TOP_HI 4'hB
`define CMA_OP_DEC_GRP 2'h1
`define CMA_OP_MUL_GRP 3'h1

`endif

// ### logic/cma_pkg.sv
// Purpose: Types shared by the core memory addressing block.
// Assumes: Used with explicit package scope only.
// Notes:   Constants live in cma_consts.svh.
package cma_pkg;

  typedef enum logic [1:0]
  {
    CMA_SEQ_RUN = 2'b00,
    CMA_SEQ_SECOND = 2'b01,
    CMA_SEQ_SKIP = 2'b10
  } cma_seq_t;

  typedef enum logic [2:0]
  {
    CMA_OP_NONE = 3'b000,
    CMA_OP_GOTO = 3'b001,
    CMA_OP_CALL = 3'b010,
    CMA_OP_FMOVE = 3'b011,
    CMA_OP_LFSR = 3'b100
  } cma_op_t;

  typedef enum logic [1:0]
  {
    CMA_SRC_RAM = 2'b00,
    CMA_SRC_BANKPTR = 2'b01,
    CMA_SRC_ZERO = 2'b10
  } cma_src_t;

endpackage : cma_pkg

// ### logic/cma_mem_if.sv
// Purpose: Carrier between the addressing logic and the shared data RAM.
// Assumes: Port a belongs to the core, port b to the USB transfer engine.
// Notes:   Clock is passed to the modules separately.
`timescale 1ns/1ps
interface cma_mem_if;
  logic [11:0] a_raddr;
  logic a_re;
  logic [11:0] a_waddr;
  logic a_we;
  logic [7:0] a_wdata;
  logic [7:0] a_rdata;
  logic [11:0] b_addr;
  logic b_re;
  logic b_we;
  logic [7:0] b_wdata;
  logic [7:0] b_rdata;

  modport ctrl
  (
    output a_raddr, a_re, a_waddr, a_we, a_wdata, b_addr, b_re, b_we,
    output b_wdata,
    input a_rdata, b_rdata
  );

  modport mem
  (
    input a_raddr, a_re, a_waddr, a_we, a_wdata, b_addr, b_re, b_we,
    input b_wdata,
    output a_rdata, b_rdata
  );
endinterface : cma_mem_if

// ### logic/cma_ram.sv
// Purpose: Dual access scratch RAM shared by core and USB transfer engine.
// Assumes: Callers only present addresses below the implemented top.
// Notes:   Read data come from registers that hold until the next read.
`timescale 1ns/1ps
`include "cma_consts.svh"
module cma_ram
(
  // Clock
  input wire logic clk_in,
  // Memory ports
  cma_mem_if.mem mem_io
);
  logic [7:0] store [0:`CMA_RAM_DEPTH-1];
  logic [7:0] a_rdata_q;
  logic [7:0] b_rdata_q;

  // Scratch contents are not cleared by reset. On a same-address clash
  // the core write is last and therefore wins.
  always_ff @(posedge clk_in)
  begin
    if (mem_io.b_we)
    begin
      store[mem_io.b_addr] <= mem_io.b_wdata;
    end
    if (mem_io.a_we)
    begin
      store[mem_io.a_waddr] <= mem_io.a_wdata;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (mem_io.a_re)
    begin
      a_rdata_q <= store[mem_io.a_raddr];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (mem_io.b_re)
    begin
      b_rdata_q <= store[mem_io.b_addr];
    end
  end

  assign mem_io.a_rdata = a_rdata_q;
  assign mem_io.b_rdata = b_rdata_q;
endmodule : cma_ram

// ### logic/cma_core.sv
// Purpose: Program counter, two-word sequencing and data address forming.
// Assumes: An outside ALU supplies skip, branch condition and write data.
// Notes:   Rules that this block carries out.
// Contract
// - Program memory is byte addressed; instructions span two or four bytes.
// - Words sit at even addresses; counter steps by 2, bit 0 reads 0.
// - Absolute jump and call load their word address into counter 20:1.
// - Relative branch offset counts words, so byte displacement is double.
// - Four two-word instructions; second word has top nibble 1111.
// - A second word right after its first supplies its literal operand.
// - A 1111 word executed alone, e.g. after a skip, is a no-op.
// - Data addresses are 12 bits: sixteen banks of 256 bytes.
// - 3904 bytes of data memory are usable.
// - Reads of unimplemented data locations return zero.
// - Fast-access map of 256 bytes ignores the bank pointer.
// - With USB enabled, shared banks are reachable by core and engine.
// - Banked address is bank pointer above the 8-bit operand.
// - Bank pointer keeps four low bits; upper bits read zero.
// - Load-bank-literal writes its immediate into the bank pointer.
// - Unimplemented-bank writes are dropped, reads give zero.
// - Move-file-to-file uses full 12-bit addresses, no bank pointer.
// - Other data instructions use bank pointer or fast map only.
// - F40h to F5Fh lie outside the fast map.
// - Fast map: 00h-5Fh on bank 0, 60h-FFh on bank 15.
// - Access bit 1 selects bank pointer, 0 selects the fast map.
`timescale 1ns/1ps
`include "cma_consts.svh"
module cma_core
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // Instruction stream
  input wire logic [15:0] INSTR_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic SKIP_IN,
  input wire logic BRANCH_TAKEN_IN,
  // Result write from the ALU
  input wire logic WR_EN_IN,
  input wire logic [7:0] WR_DATA_IN,
  // USB transfer engine port
  input wire logic USB_EN_IN,
  input wire logic USB_REQ_IN,
  input wire logic USB_WE_IN,
  input wire logic [11:0] USB_ADDR_IN,
  input wire logic [7:0] USB_WDATA_IN,
  // Program flow
  output logic [20:0] PROG_ADDR_OUT,
  output logic PC_LOAD_OUT,
  output logic CALL_PUSH_OUT,
  output logic [20:0] RET_ADDR_OUT,
  output logic WORD_NOP_OUT,
  output logic SECOND_PENDING_OUT,
  // Data read towards the ALU
  output logic [7:0] RD_DATA_OUT,
  output logic RD_VALID_OUT,
  output logic [7:0] BANK_PTR_OUT,
  // Pointer load
  output logic PTR_LOAD_OUT,
  output logic [1:0] PTR_SEL_OUT,
  output logic [11:0] PTR_VALUE_OUT,
  // USB answer
  output logic [7:0] USB_RDATA_OUT,
  output logic USB_ACK_OUT
);
  localparam logic [15:0] BANK_IMPL = `CMA_BANK_IMPL;

  cma_mem_if mem_bus ();

  cma_ram u_ram
  (
    .clk_in (CLK_IN),
    .mem_io (mem_bus)
  );

  cma_pkg::cma_seq_t seq_q;
  cma_pkg::cma_seq_t seq_d;
  cma_pkg::cma_op_t pend_op_q;
  cma_pkg::cma_src_t src_q;
  logic pending_q;
  logic [7:0] lit_q;
  logic [1:0] lfsr_sel_q;
  logic [3:0] lfsr_hi_q;
  logic [20:0] pc_q;
  logic [20:0] pc_d;
  logic [3:0] bank_q;
  logic [11:0] wr_addr_q;
  logic rd_pend_q;
  logic pc_load_q;
  logic call_push_q;
  logic [20:0] ret_addr_q;
  logic nop_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic ptr_load_q;
  logic [1:0] ptr_sel_q;
  logic [11:0] ptr_val_q;
  logic usb_ack_q;

  logic prefix_f;
  logic act_first;
  logic use_second;
  logic lone_second;
  logic skipped;
  logic is_fmove;
  logic is_goto;
  logic is_call;
  logic is_lfsr;
  logic is_two;
  logic is_ldbank;
  logic is_bra;
  logic is_rcall;
  logic is_bcond;
  logic is_file;
  logic [3:0] top;
  logic [11:0] access_addr;
  logic [11:0] file_addr;
  logic [11:0] rd_addr;
  logic rd_req;
  cma_pkg::cma_src_t rd_class;
  logic [7:0] src_val;
  logic mv_wr;
  logic wr_go;
  logic [11:0] wr_addr;
  logic [7:0] wr_data;
  cma_pkg::cma_src_t wr_class;
  logic usb_go;
  logic jump;

  // Sorts a 12-bit data address into RAM, bank pointer or empty space.
  function automatic cma_pkg::cma_src_t addr_class(input logic [11:0] a);
    cma_pkg::cma_src_t c;
    c = cma_pkg::CMA_SRC_ZERO;
    if (a <= `CMA_RAM_TOP && BANK_IMPL[a[11:8]])
    begin
      c = cma_pkg::CMA_SRC_RAM;
    end
    else if (a == `CMA_BANKPTR_ADDR)
    begin
      c = cma_pkg::CMA_SRC_BANKPTR;
    end
    return c;
  endfunction : addr_class

  // Word classification against the sequencing state.
  always_comb
  begin
    prefix_f = INSTR_IN[15:12] == `CMA_SECOND_PREFIX;
    act_first = INSTR_VALID_IN && seq_q != cma_pkg::CMA_SEQ_SKIP && !prefix_f;
    use_second = INSTR_VALID_IN && seq_q == cma_pkg::CMA_SEQ_SECOND
      && prefix_f;
    lone_second = INSTR_VALID_IN && seq_q != cma_pkg::CMA_SEQ_SECOND
      && prefix_f;
    skipped = INSTR_VALID_IN && seq_q == cma_pkg::CMA_SEQ_SKIP;
    top = INSTR_IN[15:12];
    is_fmove = act_first && top == `CMA_OP_FMOVE;
    is_goto = act_first && INSTR_IN[15:8] == `CMA_OP_GOTO;
    is_call = act_first && INSTR_IN[15:9] == `CMA_OP_CALL;
    is_lfsr = act_first && INSTR_IN[15:6] == `CMA_OP_LFSR;
    is_two = is_fmove || is_goto || is_call || is_lfsr;
    is_ldbank = act_first && INSTR_IN[15:4] == `CMA_OP_LDBANK;
    is_bra = act_first && INSTR_IN[15:11] == `CMA_OP_BRA;
    is_rcall = act_first && INSTR_IN[15:11] == `CMA_OP_RCALL;
    is_bcond = act_first && INSTR_IN[15:11] == `CMA_OP_BCOND;
    is_file = act_first
      && ((top >= `CMA_FILE_TOP_LO && top <= `CMA_FILE_TOP_HI)
      || (top == 4'h0 && INSTR_IN[11:10] == `CMA_OP_DEC_GRP)
      || (top == 4'h0 && INSTR_IN[11:9] == `CMA_OP_MUL_GRP));
  end

  // Data address forming for the word being executed.
  always_comb
  begin
    // Offsets 40h-5Fh of the high half never reach bank 15 this way.
    if (INSTR_IN[7:0] < `CMA_ACCESS_SPLIT)
    begin
      access_addr = {`CMA_ACCESS_LO_BANK, INSTR_IN[7:0]};
    end
    else
    begin
      access_addr = {`CMA_ACCESS_HI_BANK, INSTR_IN[7:0]};
    end
    if (INSTR_IN[8])
    begin
      file_addr = {bank_q, INSTR_IN[7:0]};
    end
    else
    begin
      file_addr = access_addr;
    end
    rd_addr = is_fmove ? INSTR_IN[11:0] : file_addr;
    rd_req = is_fmove || is_file;
    rd_class = addr_class(rd_addr);
  end

  // Source value of the last read, forced to zero off the map.
  always_comb
  begin
    case (src_q)
      cma_pkg::CMA_SRC_RAM: src_val = mem_bus.a_rdata;
      cma_pkg::CMA_SRC_BANKPTR: src_val = {4'h0, bank_q};
      default: src_val = 8'h00;
    endcase
  end

  // Write path: the move's second word outranks a late ALU write.
  always_comb
  begin
    mv_wr = use_second && pend_op_q == cma_pkg::CMA_OP_FMOVE;
    wr_go = mv_wr || WR_EN_IN;
    wr_addr = mv_wr ? INSTR_IN[11:0] : wr_addr_q;
    wr_data = mv_wr ? src_val : WR_DATA_IN;
    wr_class = addr_class(wr_addr);
  end

  // Shared banks only open to the engine while USB is enabled.
  always_comb
  begin
    usb_go = USB_EN_IN && USB_REQ_IN
      && USB_ADDR_IN[11:8] >= `CMA_USB_BANK_LO
      && USB_ADDR_IN[11:8] <= `CMA_USB_BANK_HI;
  end

  assign mem_bus.a_raddr = rd_addr;
  assign mem_bus.a_re = rd_req && rd_class == cma_pkg::CMA_SRC_RAM;
  assign mem_bus.a_waddr = wr_addr;
  assign mem_bus.a_we = wr_go && wr_class == cma_pkg::CMA_SRC_RAM;
  assign mem_bus.a_wdata = wr_data;
  assign mem_bus.b_addr = USB_ADDR_IN;
  assign mem_bus.b_re = usb_go && !USB_WE_IN;
  assign mem_bus.b_we = usb_go && USB_WE_IN;
  assign mem_bus.b_wdata = USB_WDATA_IN;

  // Next program counter; bit 0 is never set by any path.
  always_comb
  begin
    pc_d = pc_q + `CMA_PC_STEP;
    jump = 1'b0;
    if (use_second && (pend_op_q == cma_pkg::CMA_OP_GOTO
      || pend_op_q == cma_pkg::CMA_OP_CALL))
    begin
      pc_d = {INSTR_IN[11:0], lit_q, 1'b0};
      jump = 1'b1;
    end
    else if (is_bra || is_rcall)
    begin
      pc_d = pc_q + `CMA_PC_STEP
        + {{9{INSTR_IN[10]}}, INSTR_IN[10:0], 1'b0};
      jump = 1'b1;
    end
    else if (is_bcond && BRANCH_TAKEN_IN)
    begin
      pc_d = pc_q + `CMA_PC_STEP
        + {{12{INSTR_IN[7]}}, INSTR_IN[7:0], 1'b0};
      jump = 1'b1;
    end
  end

  // Sequencing state for skips and second words.
  always_comb
  begin
    seq_d = seq_q;
    if (INSTR_VALID_IN)
    begin
      case (seq_q)
        cma_pkg::CMA_SEQ_RUN,
        cma_pkg::CMA_SEQ_SECOND:
        begin
          if (is_two)
          begin
            seq_d = cma_pkg::CMA_SEQ_SECOND;
          end
          else if (act_first && SKIP_IN)
          begin
            seq_d = cma_pkg::CMA_SEQ_SKIP;
          end
          else
          begin
            seq_d = cma_pkg::CMA_SEQ_RUN;
          end
        end
        // A skipped first word leaves its second word to run alone.
        cma_pkg::CMA_SEQ_SKIP: seq_d = cma_pkg::CMA_SEQ_RUN;
        default: seq_d = cma_pkg::CMA_SEQ_RUN;
      endcase
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      seq_q <= cma_pkg::CMA_SEQ_RUN;
      pending_q <= 1'b0;
      pend_op_q <= cma_pkg::CMA_OP_NONE;
      lit_q <= 8'h00;
      lfsr_sel_q <= 2'h0;
      lfsr_hi_q <= 4'h0;
    end
    else if (INSTR_VALID_IN)
    begin
      seq_q <= seq_d;
      pending_q <= is_two;
      lit_q <= INSTR_IN[7:0];
      lfsr_sel_q <= INSTR_IN[5:4];
      lfsr_hi_q <= INSTR_IN[3:0];
      if (is_goto)
      begin
        pend_op_q <= cma_pkg::CMA_OP_GOTO;
      end
      else if (is_call)
      begin
        pend_op_q <= cma_pkg::CMA_OP_CALL;
      end
      else if (is_fmove)
      begin
        pend_op_q <= cma_pkg::CMA_OP_FMOVE;
      end
      else if (is_lfsr)
      begin
        pend_op_q <= cma_pkg::CMA_OP_LFSR;
      end
      else
      begin
        pend_op_q <= cma_pkg::CMA_OP_NONE;
      end
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      pc_q <= `CMA_PC_RESET;
      pc_load_q <= 1'b0;
      call_push_q <= 1'b0;
      ret_addr_q <= `CMA_PC_RESET;
      nop_q <= 1'b0;
    end
    else
    begin
      pc_load_q <= INSTR_VALID_IN && jump;
      call_push_q <= is_rcall || (use_second
        && pend_op_q == cma_pkg::CMA_OP_CALL);
      nop_q <= skipped || lone_second;
      if (INSTR_VALID_IN)
      begin
        pc_q <= pc_d;
        ret_addr_q <= pc_q + `CMA_PC_STEP;
      end
    end
  end

  // Bank pointer: the literal load is newer than any pending ALU write.
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      bank_q <= `CMA_BANKPTR_RESET;
    end
    else if (is_ldbank)
    begin
      bank_q <= INSTR_IN[3:0];
    end
    else if (wr_go && wr_class == cma_pkg::CMA_SRC_BANKPTR)
    begin
      bank_q <= wr_data[3:0];
    end
  end

  // Read return and the address that a later ALU write lands on.
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      src_q <= cma_pkg::CMA_SRC_ZERO;
      wr_addr_q <= 12'h000;
      rd_pend_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      if (rd_req)
      begin
        src_q <= rd_class;
      end
      if (is_file)
      begin
        wr_addr_q <= file_addr;
      end
      rd_pend_q <= is_file;
      rd_valid_q <= rd_pend_q;
      if (rd_pend_q)
      begin
        rd_data_q <= src_val;
      end
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      ptr_load_q <= 1'b0;
      ptr_sel_q <= 2'h0;
      ptr_val_q <= 12'h000;
    end
    else
    begin
      ptr_load_q <= use_second && pend_op_q == cma_pkg::CMA_OP_LFSR;
      if (use_second && pend_op_q == cma_pkg::CMA_OP_LFSR)
      begin
        ptr_sel_q <= lfsr_sel_q;
        ptr_val_q <= {lfsr_hi_q, INSTR_IN[7:0]};
      end
    end
  end

  // Bank 4 descriptors are the engine's business; nothing here guards them.
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      usb_ack_q <= 1'b0;
    end
    else
    begin
      usb_ack_q <= usb_go;
    end
  end

  assign PROG_ADDR_OUT = pc_q;
  assign PC_LOAD_OUT = pc_load_q;
  assign CALL_PUSH_OUT = call_push_q;
  assign RET_ADDR_OUT = ret_addr_q;
  assign WORD_NOP_OUT = nop_q;
  assign SECOND_PENDING_OUT = pending_q;
  assign RD_DATA_OUT = rd_data_q;
  assign RD_VALID_OUT = rd_valid_q;
  assign BANK_PTR_OUT = {4'h0, bank_q};
  assign PTR_LOAD_OUT = ptr_load_q;
  assign PTR_SEL_OUT = ptr_sel_q;
  assign PTR_VALUE_OUT = ptr_val_q;
  assign USB_RDATA_OUT = mem_bus.b_rdata;
  assign USB_ACK_OUT = usb_ack_q;
endmodule : cma_core

// ### testbench/cma_core_props.sv
// Purpose: Port-level checks on the core memory addressing block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Skip and first-word state are rebuilt here from the inputs.
`timescale 1ns/1ps
module cma_core_props
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // Stimulus
  input wire logic [15:0] INSTR_IN,
  input wire logic INSTR_VALID_IN,
  input wire logic SKIP_IN,
  input wire logic USB_EN_IN,
  input wire logic USB_REQ_IN,
  input wire logic [11:0] USB_ADDR_IN,
  // Responses
  input wire logic [20:0] PROG_ADDR_OUT,
  input wire logic PC_LOAD_OUT,
  input wire logic WORD_NOP_OUT,
  input wire logic SECOND_PENDING_OUT,
  input wire logic [7:0] RD_DATA_OUT,
  input wire logic RD_VALID_OUT,
  input wire logic [7:0] BANK_PTR_OUT,
  input wire logic USB_ACK_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  logic armed_q;
  logic [15:0] w1_q;
  logic [20:0] step_tgt;
  logic [20:0] rel_tgt;
  logic [20:0] jump_tgt;
  logic [7:0] lit;

  // A skip on a skipped word or a second word has no effect.
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      armed_q <= 1'b0;
    else if (INSTR_VALID_IN)
      armed_q <= SKIP_IN && !armed_q && !SECOND_PENDING_OUT;
  end

  // A skipped first word is blanked so that no target is expected.
  always_ff @(posedge CLK_IN)
  begin
    if (INSTR_VALID_IN)
      w1_q <= armed_q ? 16'h0000 : INSTR_IN;
  end

  assign step_tgt = PROG_ADDR_OUT + 21'h2;
  assign rel_tgt = step_tgt + {{9{INSTR_IN[10]}}, INSTR_IN[10:0], 1'b0};
  assign jump_tgt = {INSTR_IN[11:0], w1_q[7:0], 1'b0};
  assign lit = {4'h0, INSTR_IN[3:0]};

  sequence s_exec;
    INSTR_VALID_IN && !armed_q && !SECOND_PENDING_OUT;
  endsequence
  sequence s_file;
    s_exec ##0 (INSTR_IN[15:12] inside {[4'h2:4'hB]});
  endsequence

  property p_pc_even;
    PROG_ADDR_OUT[0] == 1'b0;
  endproperty
  property p_nop;
    INSTR_VALID_IN && (armed_q || (INSTR_IN[15:12] == 4'hF
      && !SECOND_PENDING_OUT)) |=> WORD_NOP_OUT
      && PROG_ADDR_OUT == $past(step_tgt);
  endproperty
  property p_pend;
    s_exec ##0 (INSTR_IN[15:8] == 8'hEF) |=> SECOND_PENDING_OUT;
  endproperty
  property p_jump;
    INSTR_VALID_IN && SECOND_PENDING_OUT && w1_q[15:8] == 8'hEF
      && INSTR_IN[15:12] == 4'hF |=> PC_LOAD_OUT
      && PROG_ADDR_OUT == $past(jump_tgt);
  endproperty
  property p_bra;
    s_exec ##0 (INSTR_IN[15:11] == 5'h1A) |=> PC_LOAD_OUT
      && PROG_ADDR_OUT == $past(rel_tgt);
  endproperty
  property p_load_bank_literal;
    s_exec ##0 (INSTR_IN[15:4] == 12'h010) |=> BANK_PTR_OUT == $past(lit);
  endproperty
  property p_bank_hi;
    BANK_PTR_OUT[7:4] == 4'h0;
  endproperty
  property p_rdv;
    s_file |-> ##2 RD_VALID_OUT;
  endproperty
  property p_empty;
    s_file ##0 (INSTR_IN[8] && BANK_PTR_OUT[3:0] == 4'hF
      && INSTR_IN[7:5] == 3'h2) |-> ##2 RD_VALID_OUT && RD_DATA_OUT == 8'h00;
  endproperty
  property p_usb_ack;
    USB_REQ_IN && USB_EN_IN && USB_ADDR_IN[11:10] == 2'h1 |=> USB_ACK_OUT;
  endproperty
  property p_usb_no;
    !(USB_REQ_IN && USB_EN_IN && USB_ADDR_IN[11:10] == 2'h1)
      |=> !USB_ACK_OUT;
  endproperty

  a_pc_even: assert property (p_pc_even)
    else $error("program address is odd");
  a_nop: assert property (p_nop)
    else $error("lone or skipped word did not act as a no-op");
  a_pend: assert property (p_pend)
    else $error("second-word flag not set after a first word");
  a_jump: assert property (p_jump)
    else $error("absolute jump target wrong");
  a_bra: assert property (p_bra)
    else $error("relative branch target wrong");
  a_load_bank_literal: assert property (p_load_bank_literal)
    else $error("bank literal not loaded");
  a_bank_hi: assert property (p_bank_hi)
    else $error("bank pointer upper bits not zero");
  a_rdv: assert property (p_rdv)
    else $error("file operand not delivered");
  a_empty: assert property (p_empty)
    else $error("empty location did not read zero");
  a_usb_ack: assert property (p_usb_ack)
    else $error("engine access not acknowledged");
  a_usb_no: assert property (p_usb_no)
    else $error("refused engine access acknowledged");
endmodule : cma_core_props

bind cma_core cma_core_props i_cma_core_props
(
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .INSTR_IN(INSTR_IN),
  .INSTR_VALID_IN(INSTR_VALID_IN), .SKIP_IN(SKIP_IN),
  .USB_EN_IN(USB_EN_IN), .USB_REQ_IN(USB_REQ_IN),
  .USB_ADDR_IN(USB_ADDR_IN), .PROG_ADDR_OUT(PROG_ADDR_OUT),
  .PC_LOAD_OUT(PC_LOAD_OUT), .WORD_NOP_OUT(WORD_NOP_OUT),
  .SECOND_PENDING_OUT(SECOND_PENDING_OUT), .RD_DATA_OUT(RD_DATA_OUT),
  .RD_VALID_OUT(RD_VALID_OUT), .BANK_PTR_OUT(BANK_PTR_OUT),
  .USB_ACK_OUT(USB_ACK_OUT)
);

// ### testbench/cma_usb_model.sv
// Purpose: Behavioural USB transfer engine on the shared buffer port.
// Assumes: One-cycle requests, answered one cycle later.
// Notes:   Idle address and data show the inverse of the last value.
`timescale 1ns/1ps
module cma_usb_model
(
  // Clock
  input wire logic clk_in,
  // Answer from the core
  input wire logic ack_in,
  input wire logic [7:0] rdata_in,
  // Request to the core
  output logic req_out,
  output logic we_out,
  output logic [11:0] addr_out,
  output logic [7:0] wdata_out
);
  initial
  begin
    req_out = 1'b0;
    we_out = 1'b0;
    addr_out = 12'h000;
    wdata_out = 8'h00;
  end

  // Bank 4 holds the engine's buffer bookkeeping while enabled.
  task automatic access(input logic we, input logic [11:0] a,
    input logic [7:0] d, output logic ok, output logic [7:0] q);
    @(negedge clk_in);
    req_out = 1'b1;
    we_out = we;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    req_out = 1'b0;
    we_out = ~we;
    addr_out = ~a;
    wdata_out = ~d;
    ok = ack_in;
    q = rdata_in;
  endtask : access
endmodule : cma_usb_model

// ### testbench/test_core_memory_addressing.sv
// Purpose: Self-checking bench for the core memory addressing block.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Core software keeps out of bank 4; the engine model owns it.
`timescale 1ns/1ps
module test_core_memory_addressing;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic vld = 1'b0;
  logic skip = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic usb_en = 1'b1;
  logic taken = 1'b0;
  logic usb_req, usb_we, pcl, push, wnop, pend, rdv, pld, uack;
  logic [11:0] usb_addr, pval;
  logic [7:0] usb_wdata, rd, bp, urd;
  logic [20:0] pa, ret;
  logic [1:0] psel;
  int fail_count = 0;
  int tests_run = 0;

  always #2.5 clk = ~clk;

  cma_core i_cma_core
  (
    .CLK_IN(clk), .RESET_IN(rst), .INSTR_IN(instr),
    .INSTR_VALID_IN(vld), .SKIP_IN(skip), .BRANCH_TAKEN_IN(taken),
    .WR_EN_IN(wr_en), .WR_DATA_IN(wr_data), .USB_EN_IN(usb_en),
    .USB_REQ_IN(usb_req), .USB_WE_IN(usb_we), .USB_ADDR_IN(usb_addr),
    .USB_WDATA_IN(usb_wdata), .PROG_ADDR_OUT(pa), .PC_LOAD_OUT(pcl),
    .CALL_PUSH_OUT(push), .RET_ADDR_OUT(ret), .WORD_NOP_OUT(wnop),
    .SECOND_PENDING_OUT(pend), .RD_DATA_OUT(rd), .RD_VALID_OUT(rdv),
    .BANK_PTR_OUT(bp), .PTR_LOAD_OUT(pld), .PTR_SEL_OUT(psel),
    .PTR_VALUE_OUT(pval), .USB_RDATA_OUT(urd), .USB_ACK_OUT(uack)
  );

  cma_usb_model i_cma_usb_model
  (
    .clk_in(clk), .ack_in(uack), .rdata_in(urd), .req_out(usb_req),
    .we_out(usb_we), .addr_out(usb_addr), .wdata_out(usb_wdata)
  );

  task chk(input string n, input logic [20:0] s, input logic [20:0] e);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task ex(input logic [15:0] w, input logic s = 1'b0,
    input logic t = 1'b0);
    @(negedge clk);
    instr = w;
    vld = 1'b1;
    skip = s;
    taken = t;
    wr_en = 1'b0;
  endtask : ex

  task gap(input int n);
    repeat (n)
    begin
      @(negedge clk);
      vld = 1'b0;
      skip = 1'b0;
      wr_en = 1'b0;
    end
  endtask : gap

  // The ALU write lands on the address of the latest file operation.
  task wrf(input logic [15:0] w, input logic [7:0] d);
    ex(w);
    @(negedge clk);
    vld = 1'b0;
    wr_en = 1'b1;
    wr_data = d;
    gap(1);
  endtask : wrf

  task rdf(input string n, input logic [15:0] w, input logic [7:0] e);
    ex(w);
    gap(2);
    chk(n, 21'(rdv), 21'h1);
    chk(n, 21'(rd), 21'(e));
  endtask : rdf

  task ub(input string n, input logic we, input logic [11:0] a,
    input logic [7:0] d, input logic ea, input logic [7:0] ed);
    logic ok;
    logic [7:0] q;
    i_cma_usb_model.access(we, a, d, ok, q);
    chk(n, 21'(ok), 21'(ea));
    if (ea && !we)
      chk(n, 21'(q), 21'(ed));
  endtask : ub

  task conclude;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    #20000;
    fail_count++;
    $display("[ERR] watchdog expected finish seen hang");
    conclude;
  end

  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("pc reset", pa, 21'h0);
    chk("bank reset", 21'(bp), 21'h0);
    ex(16'h0E55);
    gap(1);
    chk("pc step", pa, 21'h2);
    ex(16'hEF03);
    gap(1);
    chk("pending", 21'(pend), 21'h1);
    chk("pc first", pa, 21'h4);
    ex(16'hF000);
    gap(1);
    chk("jump load", 21'(pcl), 21'h1);
    chk("jump pc", pa, 21'h6);
    $display("test flow done");
    ex(16'hD003);
    gap(1);
    chk("bra fwd", pa, 21'hE);
    ex(16'hD7FF);
    gap(1);
    chk("bra back", pa, 21'hE);
    ex(16'hE0FF, 1'b0, 1'b1);
    gap(1);
    chk("bcond load", 21'(pcl), 21'h1);
    chk("bcond back", pa, 21'hE);
    ex(16'hDFFF);
    gap(1);
    chk("rcall push", 21'(push), 21'h1);
    chk("rcall pc", pa, 21'hE);
    chk("rcall ret", ret, 21'h10);
    ex(16'hEC05);
    ex(16'hF001);
    gap(1);
    chk("call push", 21'(push), 21'h1);
    chk("call pc", pa, 21'h20A);
    chk("call ret", ret, 21'h12);
    ex(16'hEE1A);
    ex(16'hF0BC);
    gap(1);
    chk("ptr load", 21'(pld), 21'h1);
    chk("ptr sel", 21'(psel), 21'h1);
    chk("ptr value", 21'(pval), 21'hABC);
    $display("test two-word done");
    ub("pre 556", 1'b1, 12'h556, 8'h11, 1'b1, 8'h00);
    ex(16'hF123);
    gap(1);
    chk("lone nop", 21'(wnop), 21'h1);
    chk("lone pc", pa, 21'h210);
    ex(16'h0E00, 1'b1);
    ex(16'hC123);
    gap(1);
    chk("skip nop", 21'(wnop), 21'h1);
    ex(16'hF556);
    gap(1);
    chk("orphan nop", 21'(wnop), 21'h1);
    chk("orphan pend", 21'(pend), 21'h0);
    chk("orphan pc", pa, 21'h216);
    ub("no move", 1'b0, 12'h556, 8'h00, 1'b1, 8'h11);
    $display("test skip done");
    ex(16'h0105);
    gap(1);
    chk("bank lit", 21'(bp), 21'h5);
    wrf(16'h2310, 8'hA5);
    ub("banked 510", 1'b0, 12'h510, 8'h00, 1'b1, 8'hA5);
    ub("usb 620", 1'b1, 12'h620, 8'h3C, 1'b1, 8'h00);
    ex(16'h0106);
    rdf("core 620", 16'h2320, 8'h3C);
    wrf(16'h2220, 8'h77);
    rdf("fast FE0", 16'h22E0, 8'h06);
    ex(16'h0100);
    rdf("bank0 020", 16'h2320, 8'h77);
    $display("test banks done");
    ex(16'h010F);
    wrf(16'h2240, 8'h55);
    wrf(16'h2340, 8'h99);
    rdf("F40", 16'h2340, 8'h00);
    rdf("fast 040", 16'h2240, 8'h55);
    wrf(16'h23E0, 8'hF3);
    chk("bank upper", 21'(bp), 21'h3);
    ex(16'h0101);
    wrf(16'h2323, 8'h5A);
    ex(16'h0105);
    ex(16'hC123);
    ex(16'hF556);
    gap(2);
    ub("move 556", 1'b0, 12'h556, 8'h00, 1'b1, 8'h5A);
    $display("test map done");
    usb_en = 1'b0;
    ub("usb off", 1'b0, 12'h510, 8'h00, 1'b0, 8'h00);
    usb_en = 1'b1;
    ub("usb bank3", 1'b1, 12'h310, 8'h12, 1'b0, 8'h00);
    ub("usb 400 w", 1'b1, 12'h400, 8'hC7, 1'b1, 8'h00);
    ub("usb 400 r", 1'b0, 12'h400, 8'h00, 1'b1, 8'hC7);
    $display("test usb done");
    conclude;
  end
endmodule : test_core_memory_addressing
